// *** core/i2c_slave_pkg.sv ***
// Constants, register map and state codes of the I2C slave engine.
package i2c_slave_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_INT_MAIN = 8'h0b;
  localparam logic [7:0] IDX_FLAGS1   = 8'h0c;
  localparam logic [7:0] IDX_BUF      = 8'h13;
  localparam logic [7:0] IDX_CTRL     = 8'h14;
  localparam logic [7:0] IDX_DIR      = 8'h87;
  localparam logic [7:0] IDX_EN1      = 8'h8c;
  localparam logic [7:0] IDX_ADDR     = 8'h93;
  localparam logic [7:0] IDX_STAT     = 8'h94;
  // Field positions.
  localparam int IRQ_BIT  = 3;
  localparam int DIR_SCL  = 3;
  localparam int DIR_SDA  = 4;
  localparam int C_WCOL   = 7;
  localparam int C_OV     = 6;
  localparam int C_EN     = 5;
  localparam int C_REL    = 4;
  localparam int S_SMP    = 7;
  localparam int S_CKE    = 6;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIR  = 8'hff;
  // Mode field codes.
  localparam logic [3:0] MODE_S7     = 4'h6;
  localparam logic [3:0] MODE_S10    = 4'h7;
  localparam logic [3:0] MODE_M_IDLE = 4'hb;
  localparam logic [3:0] MODE_S7_SP  = 4'he;
  localparam logic [3:0] MODE_S10_SP = 4'hf;
  // Bits in a byte and counter width.
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_RX     = 3'b010,
    ST_ACK    = 3'b011,
    ST_TX     = 3'b100,
    ST_TX_ACK = 3'b101
  } state_t;
endpackage : i2c_slave_pkg

// *** core/i2c_slave_core.sv ***
// I2C slave engine with start/stop events and an APB register slave.
module i2c_slave_core #(
  parameter int AW = 12
) (
  // Clock and reset.
  input  wire logic          CLK,
  input  wire logic          RST_N,
  // APB slave.
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // Bus clock pin, open drain.
  input  wire logic          SCL_I,
  output logic               SCL_O,
  output logic               SCL_OE_N,
  // Bus data pin, open drain.
  input  wire logic          SDA_I,
  output logic               SDA_O,
  output logic               SDA_OE_N
);
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic        scl_f;
  logic        sda_f;
  logic        scl_d;
  logic        sda_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic [7:0]  idx;
  logic        hit;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  wdat;
  logic [7:0]  rdata;
  logic [7:0]  int_main;
  logic [7:0]  flags_rest;
  logic [7:0]  enables1;
  logic [7:0]  own_addr;
  logic [7:0]  port_c_direction;
  logic [7:0]  data_buf;
  logic [7:0]  shift_reg;
  logic        wcol;
  logic        receive_overflow;
  logic        module_enable;
  logic        clock_release;
  logic [3:0]  mode_field;
  logic        smp;
  logic        cke;
  logic        data_not_addr;
  logic        stop_seen;
  logic        start_seen;
  logic        dir_read;
  logic        address_refresh_due;
  logic        buffer_full;
  logic        serial_irq_flag;
  logic        sda_low;
  logic        ack_ok;
  logic        mst_busy;
  logic [3:0]  cnt;
  i2c_slave_pkg::state_t state;
  logic        slv_on;
  logic        sp_irq;
  logic        tx_busy;
  logic        stretch;

  // Three-stage sampling; a level counts once stages two and three agree.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_q <= {scl_q[1:0], SCL_I};
      sda_q <= {sda_q[1:0], SDA_I};
      if (scl_q[1] == scl_q[2]) begin
        scl_f <= scl_q[2];
      end
      if (sda_q[1] == sda_q[2]) begin
        sda_f <= sda_q[2];
      end
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Bus events from the filtered levels.
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_ev = sda_d & ~sda_f & scl_f & scl_d;
  assign stop_ev  = ~sda_d & sda_f & scl_f & scl_d;

  // Mode decode: which modes run the slave and which report start and stop.
  assign slv_on = module_enable && (mode_field == i2c_slave_pkg::MODE_S7 ||
                  mode_field == i2c_slave_pkg::MODE_S10 ||
                  mode_field == i2c_slave_pkg::MODE_S7_SP ||
                  mode_field == i2c_slave_pkg::MODE_S10_SP);
  assign sp_irq = mode_field == i2c_slave_pkg::MODE_S7_SP ||
                  mode_field == i2c_slave_pkg::MODE_S10_SP ||
                  mode_field == i2c_slave_pkg::MODE_M_IDLE;
  assign tx_busy = (state == i2c_slave_pkg::ST_TX) && (cnt != i2c_slave_pkg::CNT_ZERO);
  assign stretch = (state == i2c_slave_pkg::ST_TX) && !clock_release &&
                   (cnt == i2c_slave_pkg::CNT_ZERO);

  // APB decode; only aligned words inside the map are taken.
  assign idx  = PADDR[9:2];
  assign acc  = PSEL && PENABLE && PREADY;
  assign wr   = acc && PWRITE && hit;
  assign rd   = acc && !PWRITE && hit;
  assign wdat = PWDATA[7:0];
  always_comb begin
    hit = (PADDR[1:0] == 2'h0) && (PADDR[AW-1:10] == '0);
    case (idx)
      i2c_slave_pkg::IDX_INT_MAIN: rdata = int_main;
      i2c_slave_pkg::IDX_FLAGS1: begin
        rdata = flags_rest;
        rdata[i2c_slave_pkg::IRQ_BIT] = serial_irq_flag;
      end
      i2c_slave_pkg::IDX_BUF:  rdata = data_buf;
      i2c_slave_pkg::IDX_CTRL: rdata = {wcol, receive_overflow, module_enable,
                                        clock_release, mode_field};
      i2c_slave_pkg::IDX_DIR:  rdata = port_c_direction;
      i2c_slave_pkg::IDX_EN1:  rdata = enables1;
      i2c_slave_pkg::IDX_ADDR: rdata = own_addr;
      i2c_slave_pkg::IDX_STAT: rdata = {smp, cke, data_not_addr, stop_seen, start_seen,
                                        dir_read, address_refresh_due, buffer_full};
      default: begin
        rdata = i2c_slave_pkg::RST_ZERO;
        hit   = 1'b0;
      end
    endcase
  end

  // Answer one cycle after setup, so every access has no wait state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      if (PSEL && !PENABLE) begin
        PRDATA <= {24'h0, hit ? rdata : i2c_slave_pkg::RST_ZERO};
      end
    end
  end

  // Plain storage registers that no hardware event touches.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_main   <= i2c_slave_pkg::RST_ZERO;
      flags_rest <= i2c_slave_pkg::RST_ZERO;
      enables1   <= i2c_slave_pkg::RST_ZERO;
      own_addr   <= i2c_slave_pkg::RST_ZERO;
    end else if (wr) begin
      if (idx == i2c_slave_pkg::IDX_INT_MAIN) begin
        int_main <= wdat;
      end
      if (idx == i2c_slave_pkg::IDX_FLAGS1) begin
        flags_rest <= wdat & ~(8'h1 << i2c_slave_pkg::IRQ_BIT);
      end
      if (idx == i2c_slave_pkg::IDX_EN1) begin
        enables1 <= wdat;
      end
      if (idx == i2c_slave_pkg::IDX_ADDR) begin
        own_addr <= wdat;
      end
    end
  end

  // Serial engine and the registers it shares with software. Software
  // effects come first so that a hardware set in the same cycle wins.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_c_direction    <= i2c_slave_pkg::RST_DIR;
      data_buf            <= i2c_slave_pkg::RST_ZERO;
      shift_reg           <= i2c_slave_pkg::RST_ZERO;
      wcol                <= 1'b0;
      receive_overflow    <= 1'b0;
      module_enable       <= 1'b0;
      clock_release       <= 1'b0;
      mode_field          <= 4'h0;
      smp                 <= 1'b0;
      cke                 <= 1'b0;
      data_not_addr       <= 1'b0;
      stop_seen           <= 1'b0;
      start_seen          <= 1'b0;
      dir_read            <= 1'b0;
      address_refresh_due <= 1'b0;
      buffer_full         <= 1'b0;
      serial_irq_flag     <= 1'b0;
      sda_low             <= 1'b0;
      ack_ok              <= 1'b0;
      mst_busy            <= 1'b0;
      cnt                 <= i2c_slave_pkg::CNT_ZERO;
      state               <= i2c_slave_pkg::ST_IDLE;
    end else begin
      // A buffer write mid-byte would corrupt the wire, so it only flags a collision.
      if (wr && idx == i2c_slave_pkg::IDX_BUF) begin
        if (tx_busy) begin
          wcol <= 1'b1;
        end else begin
          data_buf  <= wdat;
          shift_reg <= wdat;
        end
      end
      if (wr && idx == i2c_slave_pkg::IDX_CTRL) begin
        wcol             <= wdat[i2c_slave_pkg::C_WCOL];
        receive_overflow <= wdat[i2c_slave_pkg::C_OV];
        module_enable    <= wdat[i2c_slave_pkg::C_EN];
        clock_release    <= wdat[i2c_slave_pkg::C_REL];
        mode_field       <= wdat[3:0];
      end
      if (wr && idx == i2c_slave_pkg::IDX_STAT) begin
        smp <= wdat[i2c_slave_pkg::S_SMP];
        cke <= wdat[i2c_slave_pkg::S_CKE];
      end
      if (wr && idx == i2c_slave_pkg::IDX_FLAGS1) begin
        serial_irq_flag <= wdat[i2c_slave_pkg::IRQ_BIT];
      end
      if (wr && idx == i2c_slave_pkg::IDX_DIR) begin
        port_c_direction <= wdat;
        if (!wdat[i2c_slave_pkg::DIR_SDA] || !wdat[i2c_slave_pkg::DIR_SCL]) begin
          mst_busy <= 1'b1;
        end
      end
      if (rd && idx == i2c_slave_pkg::IDX_BUF) begin
        buffer_full <= 1'b0;
      end
      // Bus conditions take priority over the byte sequence.
      if (!module_enable) begin
        start_seen <= 1'b0;
        stop_seen  <= 1'b0;
        sda_low    <= 1'b0;
        state      <= i2c_slave_pkg::ST_IDLE;
      end else if (start_ev) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
        if (sp_irq) begin
          serial_irq_flag <= 1'b1;
        end
        sda_low <= 1'b0;
        cnt     <= i2c_slave_pkg::CNT_ZERO;
        state   <= slv_on ? i2c_slave_pkg::ST_ADDR : i2c_slave_pkg::ST_IDLE;
      end else if (stop_ev) begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
        if (sp_irq || enables1[i2c_slave_pkg::IRQ_BIT]) begin
          serial_irq_flag <= 1'b1;
        end
        mst_busy <= 1'b0;
        sda_low  <= 1'b0;
        state    <= i2c_slave_pkg::ST_IDLE;
      end else begin
        case (state)
          i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_f};
              cnt       <= cnt + i2c_slave_pkg::CNT_ONE;
            end else if (scl_fall && cnt == i2c_slave_pkg::BITS_BYTE) begin
              cnt <= i2c_slave_pkg::CNT_ZERO;
              if (state == i2c_slave_pkg::ST_ADDR) begin
                if (shift_reg[7:1] == own_addr[7:1]) begin
                  dir_read      <= shift_reg[0];
                  data_not_addr <= 1'b0;
                  if (!buffer_full && !receive_overflow) begin
                    data_buf    <= shift_reg;
                    buffer_full <= 1'b1;
                    sda_low     <= 1'b1;
                  end else begin
                    receive_overflow <= 1'b1;
                  end
                  state <= i2c_slave_pkg::ST_ACK;
                end else begin
                  state <= i2c_slave_pkg::ST_IDLE;
                end
              end else begin
                data_not_addr <= 1'b1;
                if (!buffer_full) begin
                  data_buf    <= shift_reg;
                  buffer_full <= 1'b1;
                  sda_low     <= !receive_overflow;
                end else begin
                  receive_overflow <= 1'b1;
                end
                state <= i2c_slave_pkg::ST_ACK;
              end
            end
          end
          i2c_slave_pkg::ST_ACK: begin
            if (scl_fall) begin
              serial_irq_flag <= 1'b1;
              sda_low         <= 1'b0;
              if (dir_read && !data_not_addr) begin
                clock_release <= 1'b0;
                state         <= i2c_slave_pkg::ST_TX;
              end else begin
                state <= i2c_slave_pkg::ST_RX;
              end
            end
          end
          i2c_slave_pkg::ST_TX: begin
            // Data changes only while the clock is low.
            if (!scl_f) begin
              sda_low <= ~shift_reg[7];
            end
            if (scl_fall) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              cnt       <= cnt + i2c_slave_pkg::CNT_ONE;
              if (cnt == i2c_slave_pkg::BITS_BYTE - i2c_slave_pkg::CNT_ONE) begin
                state <= i2c_slave_pkg::ST_TX_ACK;
              end
            end
          end
          i2c_slave_pkg::ST_TX_ACK: begin
            sda_low <= 1'b0;
            if (scl_rise) begin
              ack_ok <= ~sda_f;
            end else if (scl_fall) begin
              serial_irq_flag <= 1'b1;
              cnt             <= i2c_slave_pkg::CNT_ZERO;
              if (ack_ok) begin
                clock_release <= 1'b0;
                state         <= i2c_slave_pkg::ST_TX;
              end else begin
                dir_read            <= 1'b0;
                data_not_addr       <= 1'b0;
                address_refresh_due <= 1'b0;
                buffer_full         <= 1'b0;
                state               <= i2c_slave_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            state <= i2c_slave_pkg::ST_IDLE;
          end
        endcase
      end
      // Lost arbitration: we released data but the wire reads low.
      if (module_enable && mst_busy && scl_rise && port_c_direction[i2c_slave_pkg::DIR_SDA] &&
          !sda_f && !sda_low) begin
        port_c_direction[i2c_slave_pkg::DIR_SDA] <= 1'b1;
        port_c_direction[i2c_slave_pkg::DIR_SCL] <= 1'b1;
        mst_busy                                 <= 1'b0;
      end
    end
  end

  // Open-drain pins: the level is always low, only the enable moves.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SCL_O    <= 1'b0;
      SDA_O    <= 1'b0;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
    end else begin
      SCL_O    <= 1'b0;
      SDA_O    <= 1'b0;
      SCL_OE_N <= !(module_enable && (!port_c_direction[i2c_slave_pkg::DIR_SCL] ||
                  stretch));
      SDA_OE_N <= !(module_enable && (!port_c_direction[i2c_slave_pkg::DIR_SDA] ||
                  sda_low));
    end
  end
endmodule : i2c_slave_core

// *** verif/i2c_slave_properties.sv ***
// Port-level checks on the I2C slave engine, bound into its top module.
module i2c_slave_checker #(
  parameter int AW = 12
) (
  // Clock and reset.
  input wire logic          CLK,
  input wire logic          RST_N,
  // APB slave.
  input wire logic          PSEL,
  input wire logic          PENABLE,
  input wire logic          PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0]   PWDATA,
  input wire logic [31:0]   PRDATA,
  input wire logic          PREADY,
  input wire logic          PSLVERR,
  // Bus pins.
  input wire logic          SCL_I,
  input wire logic          SCL_O,
  input wire logic          SCL_OE_N,
  input wire logic          SDA_I,
  input wire logic          SDA_O,
  input wire logic          SDA_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ctrl_wr;
  logic       any_wr;
  logic [3:0] since_wr;
  assign ctrl_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR[9:2] == i2c_slave_pkg::IDX_CTRL;
  assign any_wr  = ctrl_wr || (PSEL && PENABLE && PREADY && PWRITE &&
                               PADDR[9:2] == i2c_slave_pkg::IDX_DIR);
  // Cycles since software touched control or direction; saturates so it never wraps.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      since_wr <= 4'hf;
    end else if (any_wr) begin
      since_wr <= 4'h0;
    end else if (since_wr != 4'hf) begin
      since_wr <= since_wr + 4'h1;
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_error_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_misaligned_error: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'b00 |=> PSLVERR)
    else $error("misaligned access not refused");
  a_pins_drive_low: assert property (!SCL_OE_N || !SDA_OE_N |-> !SCL_O && !SDA_O)
    else $error("pin driven high");
  // Two high samples in a row: a bit's high phase is only a few cycles long.
  a_data_steady_high: assert property (SCL_I [*2] ##0 since_wr > 4'h4 |-> $stable(SDA_OE_N))
    else $error("data moved while clock high");
  a_release_by_write: assert property ($rose(SCL_OE_N) |-> since_wr < 4'h8)
    else $error("clock released without software");
  a_stretch_when_low: assert property ($fell(SCL_OE_N) |-> !SCL_I || since_wr < 4'h8)
    else $error("clock pulled while high");
  a_off_releases: assert property (ctrl_wr && !PWDATA[i2c_slave_pkg::C_EN]
                                   |-> ##[1:4] SCL_OE_N && SDA_OE_N)
    else $error("pins held after disable");
  a_reset_idle: assert property ($rose(RST_N) |-> SCL_OE_N && SDA_OE_N && !PREADY)
    else $error("outputs busy after reset");
  c_stretch: cover property ($fell(SCL_OE_N));
  c_ack: cover property ($fell(SDA_OE_N));
  c_refused: cover property (PSLVERR);
endmodule : i2c_slave_checker

bind i2c_slave_core i2c_slave_checker #(.AW(AW)) u_checker (.CLK(CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_N(SCL_OE_N), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N));

// *** verif/i2c_master_model.sv ***
// Behavioural I2C bus master standing on the far side of the slave engine.
module i2c_master_model (
  // Pacing clock.
  input wire logic clk,
  // Resolved line levels.
  input wire logic scl_i,
  input wire logic sda_i,
  // Open-drain enables, low pulls the line.
  output logic     scl_oe_n,
  output logic     sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines are released until a frame starts.
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Start only from an idle bus: data falls while the clock is high.
  task automatic start_cond();
    sda_oe_n <= 1'b0;
    repeat (4) @(posedge clk);
    scl_oe_n <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : start_cond
  // Stop: data rises while the clock is high.
  task automatic stop_cond();
    @(posedge clk);
    sda_oe_n <= 1'b0;
    repeat (3) @(posedge clk);
    scl_oe_n <= 1'b1;
    repeat (4) @(posedge clk);
    sda_oe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop_cond
  // One bit; data moves a cycle after the fall so it never races the clock edge.
  // The low phase is long because the slave needs about seven cycles after a
  // fall to put its next bit out; a shorter one has it move data while the
  // clock is high, which the bus reads as a start or a stop.
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk);
    sda_oe_n <= b;
    repeat (7) @(posedge clk);
    scl_oe_n <= 1'b1;
    @(posedge clk);
    // A stretching slave holds the clock, so wait on the line itself.
    while (scl_i !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    r = sda_i;
    scl_oe_n <= 1'b0;
  endtask : bit_io
  // Byte to the slave, MSB first; returns the acknowledge level.
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack_n);
    repeat (8) @(posedge clk);
  endtask : send_byte
  // Byte from the slave; the caller chooses acknowledge or not.
  task automatic take_byte(input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(ack_n, r);
    repeat (8) @(posedge clk);
  endtask : take_byte
endmodule : i2c_master_model

// *** verif/i2c_slave_with_bus_events_test.sv ***
// Self-checking bench: APB software on one side, a bus master on the other.
module i2c_slave_with_bus_events_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        scl_o, sda_o, scl_oe_n, sda_oe_n, m_scl, m_sda, er, ack;
  logic [7:0]  rd, a, d, d2;
  int          fail_count, n_compared;
  integer      seed;
  // Open-drain lines with pull-ups: low if any party pulls.
  wire         scl = scl_oe_n & m_scl;
  wire         sda = sda_oe_n & m_sda;
  logic [7:0]  ridx [6] = '{8'h0c, 8'h14, 8'h87, 8'h8c, 8'h93, 8'h94};
  logic [7:0]  rrst [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  i2c_slave_core #(.AW(12)) u_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));
  i2c_master_model u_mst (.clk(clk), .scl_i(scl), .sda_i(sda), .scl_oe_n(m_scl),
    .sda_oe_n(m_sda));
  // 25 MHz core clock.
  always #20 clk = ~clk;
  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // Expected status byte built from its event fields.
  function automatic logic [7:0] st(input logic da, p, s, rw, bf);
    return {2'b00, da, p, s, rw, 1'b0, bf};
  endfunction : st
  function automatic logic [11:0] ra(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ra
  // One APB transfer; the request stands until ready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for ready.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never raises select again in this time step.
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] i, v);
    apb(1'b1, ra(i), v);
  endtask : wr
  task automatic rc(input logic [7:0] i, m, e);
    apb(1'b0, ra(i), 8'h00);
    check(rd & m, e);
  endtask : rc
  // Watchdog: the whole run needs under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    clk = 0;
    rst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    fail_count = 0;
    n_compared = 0;
    seed = 32'h2132;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ridx[i]) rc(ridx[i], 8'hff, rrst[i]);
    apb(1'b0, 12'h154, 8'h00);
    check({7'h0, er}, 8'h01);
    apb(1'b1, 12'h24e, 8'h5a);
    check({7'h0, er}, 8'h01);
    a = 8'($random(seed)) & 8'hfe;
    wr(8'h93, a);
    rc(8'h93, 8'hff, a);
    wr(8'h14, 8'h26);
    // Addressed write, then a data byte left unread to provoke overflow.
    u_mst.start_cond();
    rc(8'h94, 8'h18, st(0, 0, 1, 0, 0));
    u_mst.send_byte(a, ack);
    check({7'h0, ack}, 8'h00);
    rc(8'h94, 8'h25, st(0, 0, 0, 0, 1));
    rc(8'h0c, 8'hff, 8'h08);
    rc(8'h13, 8'hff, a);
    rc(8'h94, 8'h01, 8'h00);
    wr(8'h0c, 8'h00);
    d = 8'($random(seed));
    u_mst.send_byte(d, ack);
    check({7'h0, ack}, 8'h00);
    rc(8'h94, 8'h21, st(1, 0, 0, 0, 1));
    wr(8'h0c, 8'h00);
    u_mst.send_byte(~d, ack);
    check({7'h0, ack}, 8'h01);
    rc(8'h0c, 8'hff, 8'h08);
    rc(8'h13, 8'hff, d);
    rc(8'h14, 8'hff, 8'h66);
    u_mst.send_byte(d ^ 8'h5a, ack);
    check({7'h0, ack}, 8'h01);
    rc(8'h13, 8'hff, d ^ 8'h5a);
    wr(8'h14, 8'h26);
    u_mst.stop_cond();
    rc(8'h94, 8'h18, st(0, 1, 0, 0, 0));
    // Addressed read: one acknowledged byte, then one refused.
    u_mst.start_cond();
    u_mst.send_byte(a | 8'h01, ack);
    check({7'h0, ack}, 8'h00);
    rc(8'h94, 8'h05, 8'h05);
    rc(8'h13, 8'hff, a | 8'h01);
    wr(8'h0c, 8'h00);
    for (int k = 0; k < 2; k++) begin
      fork
        u_mst.take_byte(k[0], d2);
        begin
          repeat (40) @(posedge clk);
          check({7'h0, scl}, 8'h00);
          d = 8'($random(seed));
          wr(8'h13, d);
          wr(8'h14, 8'h36);
        end
      join
      check(d2, d);
      rc(8'h0c, 8'hff, 8'h08);
      wr(8'h0c, 8'h00);
    end
    rc(8'h94, 8'h25, 8'h00);
    u_mst.stop_cond();
    u_mst.start_cond();
    u_mst.send_byte(a ^ 8'h02, ack);
    check({7'h0, ack}, 8'h01);
    u_mst.stop_cond();
    // Firmware master mode: events flagged, no address matching.
    wr(8'h14, 8'h2b);
    wr(8'h0c, 8'h00);
    u_mst.start_cond();
    rc(8'h0c, 8'hff, 8'h08);
    wr(8'h0c, 8'h00);
    u_mst.send_byte(a, ack);
    check({7'h0, ack}, 8'h01);
    u_mst.stop_cond();
    rc(8'h0c, 8'hff, 8'h08);
    wr(8'h87, 8'he7);
    repeat (4) @(posedge clk);
    check({6'h0, scl_oe_n, sda_oe_n}, 8'h00);
    wr(8'h87, 8'hff);
    repeat (4) @(posedge clk);
    check({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    // Slave mode with the interrupt enabled: a stop alone raises the flag.
    wr(8'h14, 8'h26);
    wr(8'h8c, 8'h08);
    u_mst.start_cond();
    wr(8'h0c, 8'h00);
    u_mst.stop_cond();
    rc(8'h0c, 8'hff, 8'h08);
    wr(8'h14, 8'h00);
    rc(8'h94, 8'h18, 8'h00);
    results();
  end
endmodule : i2c_slave_with_bus_events_test
